/* verilog/external_pin_interrupt_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module external_pin_interrupt_unit #(
    parameter int NumPins = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins (read back even when driven as outputs)
    input wire logic [7:0] irqPins,
    // Processor register port
    input wire logic [7:0] regAddr,
    input wire logic dataSpace,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata_q,
    // Processor interrupt side
    input wire logic globalIntEnable,
    input wire logic [2:0] ackPin,
    input wire logic ackValid,
    input wire logic compatMode,
    input wire logic sleepEntry,
    output logic [7:0] irqRequest_q
);
    logic [7:0] pendingFlags_q;
    logic [7:0] pendingFlags_d;
    logic [7:0] enableMask_q;
    logic [7:0] upperSense_q;
    logic [7:0] lowerSense_q;
    logic [7:0] lowMeta_q;
    logic [7:0] lowSync_q;
    logic [7:0] lowPrev_q;
    logic [7:0] lowSeen;
    logic [7:0] pinLevel;
    logic [7:0] edgeSet;
    logic [7:0] levelMode;
    logic [7:0] ackClear;
    logic [7:0] wrClear;
    logic [7:0] ioAddr;
    logic [7:0] requestNext;
    logic inIoRange;
    logic selFlags;
    logic selMask;
    logic selUpper;
    logic selLower;
    logic [7:0] readMux;

    function automatic logic [1:0] fieldOf(input logic [7:0] reg8, input int idx);
        fieldOf = reg8[idx*ext_int_pkg::SenseFieldWidth +: ext_int_pkg::SenseFieldWidth];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // io versus data space
    assign ioAddr = dataSpace ? regAddr - ext_int_pkg::DataSpaceShift : regAddr;
    assign inIoRange = dataSpace ? (regAddr >= ext_int_pkg::DataSpaceShift) : 1'b1;
    assign selFlags = inIoRange && ioAddr == ext_int_pkg::PendingFlagsOffs;
    assign selMask = inIoRange && ioAddr == ext_int_pkg::EnableMaskOffs;
    // upper sense hidden in compatibility mode
    assign selUpper = inIoRange && ioAddr == ext_int_pkg::UpperSenseOffs && !compatMode;
    assign selLower = dataSpace && regAddr == ext_int_pkg::LowerSenseOffs && !compatMode;
    assign readMux = selFlags ? pendingFlags_q :
                     selMask ? enableMask_q :
                     selUpper ? upperSense_q :
                     selLower ? lowerSense_q : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Upper pins through the synchronising edge sensor
    genvar gi;
    generate
        for (gi = 4; gi < 8; gi++) begin : gUpper
            pin_edge_sense uSense (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .pinRaw(irqPins[gi]),
                .senseMode(fieldOf(upperSense_q, gi - 4)),
                .pinSync(pinLevel[gi]),
                .edgePulse(edgeSet[gi])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : gLower
            // Sync too, since the fabric has one clock; edge still without enable
            assign pinLevel[gi] = lowSeen[gi];
            assign edgeSet[gi] =
                (fieldOf(lowerSense_q, gi) == ext_int_pkg::SenseFalling) ?
                    (lowPrev_q[gi] & ~lowSeen[gi]) :
                (fieldOf(lowerSense_q, gi) == ext_int_pkg::SenseRising) ?
                    (~lowPrev_q[gi] & lowSeen[gi]) : 1'b0;
        end
        for (gi = 0; gi < 8; gi++) begin : gMode
            if (gi >= 4) begin : gU
                assign levelMode[gi] =
                    fieldOf(upperSense_q, gi - 4) == ext_int_pkg::SenseLowLevel;
            end else begin : gL
                assign levelMode[gi] =
                    fieldOf(lowerSense_q, gi) == ext_int_pkg::SenseLowLevel;
            end
        end
    endgenerate

    // sleep clamp pulls disabled lower pins low
    // Clamp sits before the compare, so entering sleep gives one falling edge
    assign lowSeen = lowSync_q & ~({4'h0, ~enableMask_q[3:0]} & {8{sleepEntry}});

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lowMeta_q <= 8'hFF;
            lowSync_q <= 8'hFF;
            lowPrev_q <= 8'hFF;
        end else begin
            lowMeta_q <= irqPins;
            lowSync_q <= lowMeta_q;
            lowPrev_q <= lowSeen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write one clears
    assign wrClear = (regWrite && selFlags) ? regWdata : 8'h00;
    assign ackClear = ackValid ? (8'h01 << ackPin) : 8'h00;
    // edge sets, set wins over clear; level mode forces zero
    assign pendingFlags_d = ((pendingFlags_q & ~wrClear & ~ackClear) | edgeSet) & ~levelMode;
    // request from flag or held low level
    assign requestNext = globalIntEnable ?
        (enableMask_q & (pendingFlags_d | (levelMode & ~pinLevel))) : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pendingFlags_q <= ext_int_pkg::PendingFlagsReset;
            enableMask_q <= ext_int_pkg::EnableMaskReset;
            upperSense_q <= ext_int_pkg::UpperSenseReset;
            lowerSense_q <= ext_int_pkg::LowerSenseReset;
            regRdata_q <= 8'h00;
            irqRequest_q <= 8'h00;
        end else begin
            pendingFlags_q <= pendingFlags_d;
            if (regWrite && selMask) begin
                enableMask_q <= regWdata;
            end
            if (regWrite && selUpper) begin
                upperSense_q <= regWdata;
            end
            if (regWrite && selLower) begin
                lowerSense_q <= regWdata;
            end
            regRdata_q <= regRead ? readMux : 8'h00;
            irqRequest_q <= requestNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_level_flag_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((pendingFlags_q & levelMode) == 8'h00) or $changed(upperSense_q)
            or $changed(lowerSense_q))
        else $error("flag set in level mode");
    a_req_needs_gie: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(globalIntEnable) |-> irqRequest_q == 8'h00)
        else $error("request without global enable");
    a_req_needs_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (irqRequest_q & ~$past(enableMask_q)) == 8'h00)
        else $error("request without mask bit");
    a_edge_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        edgeSet[7] && !levelMode[7] |=> pendingFlags_q[7])
        else $error("edge did not set flag");
    a_w1c_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrite && selFlags && regWdata[5] && !edgeSet[5] |=> !pendingFlags_q[5])
        else $error("write one did not clear");
    a_w0_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrite && selFlags && !regWdata[6] && pendingFlags_q[6] && !levelMode[6]
            && !(ackValid && ackPin == 3'h6) |=> pendingFlags_q[6])
        else $error("write zero cleared flag");
    a_level_holds_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
        globalIntEnable && enableMask_q[4] && levelMode[4] && !pinLevel[4]
            |=> irqRequest_q[4])
        else $error("level request dropped");
    a_pulse_detected: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(pinLevel[7]) && upperSense_q[7:6] == ext_int_pkg::SenseFalling
            && $stable(upperSense_q) |=> pendingFlags_q[7])
        else $error("falling pulse missed");
    a_ack_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ackValid && ackPin == 3'h2 && !edgeSet[2] |=> !pendingFlags_q[2])
        else $error("handler entry left flag");

    ////////////////////////////////////////////////////////////////////////
    // Register port checks
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(regRead) |-> regRdata_q == 8'h00)
        else $error("read data without read");

    a_read_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(regRead) && $past(selFlags) |-> regRdata_q == $past(pendingFlags_q))
        else $error("flag read wrong");

    a_read_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(regRead) && $past(selMask) |-> regRdata_q == $past(enableMask_q))
        else $error("mask read wrong");

    a_read_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(regRead) && $past(selUpper) |-> regRdata_q == $past(upperSense_q))
        else $error("sense read wrong");

    a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrite && selMask |=> enableMask_q == $past(regWdata))
        else $error("mask write lost");

    a_sense_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrite && selUpper |=> upperSense_q == $past(regWdata))
        else $error("sense write lost");

    a_compat_hides: assert property (@(posedge sys_clk) disable iff (!rst_n)
        compatMode |-> !selUpper && !selLower)
        else $error("sense register visible in compat mode");

    a_compat_nowrite: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrite && compatMode |=> $stable(upperSense_q) && $stable(lowerSense_q))
        else $error("sense written in compat mode");

    a_data_alias: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dataSpace && regAddr == 8'h5A && !compatMode |-> selUpper)
        else $error("data space alias missed");

    a_io_no_lower: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !dataSpace |-> !selLower)
        else $error("lower sense reached from io space");

    ////////////////////////////////////////////////////////////////////////
    // Sense, flag and request checks
    a_reserved_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        upperSense_q[3:2] == ext_int_pkg::SenseReserved |-> !edgeSet[5])
        else $error("reserved code raised edge");

    a_level_no_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        levelMode[4] |-> !edgeSet[4])
        else $error("edge pulse in level mode");

    a_rise_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(pinLevel[6]) && upperSense_q[5:4] == ext_int_pkg::SenseRising
            && $stable(upperSense_q) |=> pendingFlags_q[6])
        else $error("rising pulse missed");

    a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) && $past(rst_n, 2) |-> pinLevel[7] == $past(irqPins[7], 2))
        else $error("pin not sampled through two stages");

    a_edge_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        edgeSet[7] && !(regWrite && selUpper) |=> !edgeSet[7])
        else $error("edge pulse longer than one cycle");

    a_flag_needs_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(pendingFlags_q[7]) && !$past(edgeSet[7]) |-> !pendingFlags_q[7])
        else $error("flag set without edge");

    a_lower_edge_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        edgeSet[0] |=> pendingFlags_q[0])
        else $error("lower edge did not set flag");

    a_ack_clears_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ackValid && ackPin == 3'h7 && !edgeSet[7] |=> !pendingFlags_q[7])
        else $error("handler entry left top flag");

    a_w1c_lower: assert property (@(posedge sys_clk) disable iff (!rst_n)
        regWrite && selFlags && regWdata[0] && !edgeSet[0] |=> !pendingFlags_q[0])
        else $error("write one left lower flag");

    a_req_from_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        globalIntEnable && enableMask_q[7] && pendingFlags_d[7] |=> irqRequest_q[7])
        else $error("pending flag raised no request");

    a_lower_level_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
        globalIntEnable && enableMask_q[1] && levelMode[1] && !pinLevel[1]
            |=> irqRequest_q[1])
        else $error("lower level request dropped");

    a_sleep_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sleepEntry && !enableMask_q[1] |-> !lowSeen[1])
        else $error("disabled pin not clamped in sleep");

    a_sleep_keeps_enabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sleepEntry && enableMask_q[0] |-> lowSeen[0] == lowSync_q[0])
        else $error("enabled pin clamped in sleep");
endmodule
`default_nettype wire

/* verilog/ext_int_pkg.sv */
package ext_int_pkg;
    // I/O-space offsets, except LowerSenseOffs, which is a data-space address; data-space adds the shift
    localparam logic [7:0] PendingFlagsOffs = 8'h38;
    localparam logic [7:0] EnableMaskOffs = 8'h39;
    localparam logic [7:0] UpperSenseOffs = 8'h3A;
    localparam logic [7:0] LowerSenseOffs = 8'h6A;
    localparam logic [7:0] DataSpaceShift = 8'h20;
    localparam logic [7:0] IoSpaceTop = 8'h3F;
    localparam logic [7:0] PendingFlagsReset = 8'h00;
    localparam logic [7:0] EnableMaskReset = 8'h00;
    localparam logic [7:0] UpperSenseReset = 8'h00;
    localparam logic [7:0] LowerSenseReset = 8'h00;
    // Sense field codes
    localparam logic [1:0] SenseLowLevel = 2'h0;
    localparam logic [1:0] SenseReserved = 2'h1;
    localparam logic [1:0] SenseFalling = 2'h2;
    localparam logic [1:0] SenseRising = 2'h3;
    localparam int SenseFieldWidth = 2;
    localparam int SyncStages = 2;
endpackage

/* verilog/pin_edge_sense.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sense (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin and mode
    input wire logic pinRaw,
    input wire logic [1:0] senseMode,
    // Results
    output logic pinSync,
    output logic edgePulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic fall;
    logic rise;

    assign fall = prev_q & ~sync_q;
    assign rise = ~prev_q & sync_q;
    assign pinSync = sync_q;
    assign edgePulse = (senseMode == ext_int_pkg::SenseFalling) ? fall :
                       (senseMode == ext_int_pkg::SenseRising) ? rise : 1'b0;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pinRaw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
endmodule
`default_nettype wire

/* test/pin_source.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_source (
    // Clock
    input wire logic sys_clk,
    // Driven pin levels
    output logic [7:0] pins
);
    // Pins idle high, as the synchronizers assume
    initial begin
        pins = 8'hFF;
    end
    task automatic hold(input int pin, input logic lvl, input int cyc);
        @(negedge sys_clk);
        pins[pin] = lvl;
        repeat (cyc) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* test/tb_external_pin_interrupt_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_external_pin_interrupt_unit;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] irqPins;
    logic [7:0] regAddr = 8'h00;
    logic dataSpace = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata_q;
    logic gie = 1'b0;
    logic [2:0] ackPin = 3'h0;
    logic ackValid = 1'b0;
    logic compatMode = 1'b0;
    logic sleep = 1'b0;
    logic [7:0] irqRequest_q;
    int err_total = 0;
    int compares = 0;
    always #25 sys_clk = ~sys_clk;
    pin_source src (.sys_clk(sys_clk), .pins(irqPins));
    external_pin_interrupt_unit #(.NumPins(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .irqPins(irqPins), .regAddr(regAddr), .dataSpace(dataSpace), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .globalIntEnable(gie), .ackPin(ackPin), .ackValid(ackValid),
        .compatMode(compatMode), .sleepEntry(sleep), .irqRequest_q(irqRequest_q));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        chk(regRdata_q, exp);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(ext_int_pkg::PendingFlagsOffs, ext_int_pkg::PendingFlagsReset);
        rd(ext_int_pkg::EnableMaskOffs, ext_int_pkg::EnableMaskReset);
        rd(ext_int_pkg::UpperSenseOffs, ext_int_pkg::UpperSenseReset);
        rd(8'h3B, 8'h00);
    endtask
    // Sense fields written and read back; mask set to 0F through its data-space alias, then cleared
    task automatic t_sense;
        wr(8'h3A, 8'hB4);
        rd(8'h3A, 8'hB4);
        dataSpace = 1'b1;
        rd(8'h5A, 8'hB4);
        wr(8'h59, 8'h0F);
        rd(8'h39, 8'h00);
        dataSpace = 1'b0;
        rd(8'h39, 8'h0F);
        wr(8'h39, 8'h00);
    endtask
    task automatic t_edge;
        wr(8'h39, 8'h80);
        gie = 1'b1;
        src.hold(7, 1'b0, 2);
        src.hold(7, 1'b1, 4);
        chk(irqRequest_q, 8'h80);
        rd(8'h38, 8'h80);
        wr(8'h38, 8'h7F);
        rd(8'h38, 8'h80);
        wr(8'h38, 8'h80);
        rd(8'h38, 8'h00);
        chk(irqRequest_q, 8'h00);
    endtask
    task automatic t_mask;
        wr(8'h39, 8'h00);
        src.hold(6, 1'b0, 4);
        rd(8'h38, 8'h00);
        src.hold(6, 1'b1, 4);
        rd(8'h38, 8'h40);
        chk(irqRequest_q, 8'h00);
        gie = 1'b0;
        wr(8'h39, 8'h40);
        repeat (2) @(negedge sys_clk);
        chk(irqRequest_q, 8'h00);
        gie = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(irqRequest_q, 8'h40);
        ackPin = 3'h6;
        ackValid = 1'b1;
        @(negedge sys_clk);
        ackValid = 1'b0;
        rd(8'h38, 8'h00);
        wr(8'h39, 8'h20);
        src.hold(5, 1'b0, 3);
        src.hold(5, 1'b1, 4);
        rd(8'h38, 8'h00);
    endtask
    task automatic t_level;
        wr(8'h39, 8'h10);
        src.hold(4, 1'b0, 4);
        chk(irqRequest_q, 8'h10);
        rd(8'h38, 8'h00);
        chk(irqRequest_q, 8'h10);
        src.hold(4, 1'b1, 4);
        chk(irqRequest_q, 8'h00);
    endtask
    task automatic t_lower;
        compatMode = 1'b1;
        wr(8'h3A, 8'hFF);
        rd(8'h3A, 8'h00);
        compatMode = 1'b0;
        rd(8'h3A, 8'hB4);
        dataSpace = 1'b1;
        wr(8'h6A, 8'h02);
        rd(8'h6A, 8'h02);
        dataSpace = 1'b0;
        wr(8'h39, 8'h01);
        src.hold(0, 1'b0, 3);
        src.hold(0, 1'b1, 4);
        rd(8'h38, 8'h01);
        wr(8'h38, 8'h01);
        dataSpace = 1'b1;
        wr(8'h6A, 8'h0A);
        dataSpace = 1'b0;
        @(negedge sys_clk);
        sleep = 1'b1;
        repeat (2) @(negedge sys_clk);
        sleep = 1'b0;
        rd(8'h38, 8'h02);
        chk(irqRequest_q, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_sense();
        t_edge();
        t_mask();
        t_level();
        t_lower();
        complete_run();
    end
    // Whole sequence needs about 128 cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
